// ### common/wdt_map.vh
// Register offsets, field positions, reset values and timing counts
// Included by the watchdog design file and its testbench; definitions only
`ifndef WDT_MAP_VH
`define WDT_MAP_VH
`define ADDR_PERIOD_SELECT 4'h0
`define ADDR_CONTROL 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_COMMAND 4'hC
`define PERIOD_RESET 3'h7
`define KEY_RESET 4'hA
`define KEY_DISABLE 4'hA
`define PORT_RESET 8'hFF
`define CMD_CLEAR_SINGLE 0
`define CMD_CLEAR_FIRST 1
`define CMD_CLEAR_SECOND 2
`define CMD_SLEEP 3
`define CMD_WAKE 4
`define SRC_CRYSTAL 2'h0
`define SRC_SYSDIV4 2'h1
`define SRC_RC 2'h2
`define RESET_DELAY_MS 100
`define CLK_MHZ 100
`define RESET_DELAY_CYC (`RESET_DELAY_MS * 1000 * `CLK_MHZ)
`define STARTUP_LONG 1024
`define STARTUP_SHORT 2
`define TIMEOUT_BASE 8
`endif

// ### design/edge_sync.v
// Two-flop synchroniser with rising edge detect on the synchronised level
// Assumes the input is asynchronous to clk
`timescale 1ns/10ps
module edge_sync (
   input wire clk,
   input wire rst_n,
   input wire din,
   output wire level,
   output wire rise
);
   reg meta_r;
   reg sync_r;
   reg last_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end
   assign level = sync_r;
   assign rise = sync_r & ~last_r;
endmodule // edge_sync

// ### design/watchdog_and_reset_sources.v
// Watchdog timer and reset sequencer with an AXI4-Lite register slave
// Assumes the core issues clear/sleep commands as one-cycle pulses
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "wdt_map.vh"
module watchdog_and_reset_sources #(
   parameter RESET_DELAY = `RESET_DELAY_CYC,
   parameter STARTUP_LONG = `STARTUP_LONG,
   parameter STARTUP_SHORT = `STARTUP_SHORT
) (
   input wire sys_clk,
   input wire rst_n,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire cfgWdtEnable,
   input wire [1:0] cfgClkSource,
   input wire cfgPairClear,
   input wire cfgShortStartup,
   input wire cfgRcSysClock,
   input wire externalResetPinN,
   input wire lowVoltageReset,
   input wire lowFreqCrystalClock,
   input wire lowSpeedInternalRc,
   input wire [4:0] coreCmd,
   output reg coreResetN,
   output reg pcSpReset,
   output reg wakeUp,
   output reg sleeping,
   output reg timeoutFlag,
   output reg [7:0] portData,
   output reg [7:0] portControl
);
   localparam ST_HOLD = 3'b001;
   localparam ST_DELAY = 3'b010;
   localparam ST_RUN = 3'b100;
   localparam [10:0] START_LONG_CNT = STARTUP_LONG - 1;
   localparam [10:0] START_SHORT_CNT = STARTUP_SHORT - 1;

   wire crystalTick;
   wire rcTick;
   wire pinLevel;
   wire lvrLevel;
   reg [2:0] periodSel_r;
   reg [3:0] enableKey_r;
   reg [15:0] count_r;
   reg [1:0] div4_r;
   reg lastPair_r;
   reg pairSeen_r;
   reg [2:0] state_r;
   reg [31:0] delay_r;
   reg [10:0] startup_r;
   reg starting_r;
   reg portInit_r;

   edge_sync crystalSync (
      .clk(sys_clk),
      .rst_n(rst_n),
      .din(lowFreqCrystalClock),
      .level(),
      .rise(crystalTick)
   );
   edge_sync rcSync (
      .clk(sys_clk),
      .rst_n(rst_n),
      .din(lowSpeedInternalRc),
      .level(),
      .rise(rcTick)
   );
   edge_sync pinSync (
      .clk(sys_clk),
      .rst_n(rst_n),
      .din(externalResetPinN),
      .level(pinLevel),
      .rise()
   );
   edge_sync lvrSync (
      .clk(sys_clk),
      .rst_n(rst_n),
      .din(lowVoltageReset),
      .level(lvrLevel),
      .rise()
   );

   // Pin low or low voltage both act as an external reset
   wire extReset = ~pinLevel | lvrLevel;
   wire running = (state_r == ST_RUN);
   wire active = cfgWdtEnable | (enableKey_r != `KEY_DISABLE);
   wire sysTick = running & ~sleeping & (div4_r == 2'h3);
   reg wdtTick;
   always @* begin
      case (cfgClkSource)
         `SRC_CRYSTAL: wdtTick = crystalTick;
         `SRC_SYSDIV4: wdtTick = sysTick;
         default: wdtTick = rcTick;
      endcase
   end

   wire cmdSingle = coreCmd[`CMD_CLEAR_SINGLE] & running & ~starting_r;
   wire cmdFirst = coreCmd[`CMD_CLEAR_FIRST] & running & ~starting_r;
   wire cmdSecond = coreCmd[`CMD_CLEAR_SECOND] & running & ~starting_r;
   wire cmdSleep = coreCmd[`CMD_SLEEP] & running & ~starting_r;
   wire cmdWake = coreCmd[`CMD_WAKE] & sleeping;
   // Second of pair only counts when it differs from the last one seen
   wire pairHit = (cmdFirst & (~pairSeen_r | lastPair_r)) |
      (cmdSecond & (~pairSeen_r | ~lastPair_r));
   wire swClear = active & (cfgPairClear ? pairHit : cmdSingle);
   wire [15:0] limit = 16'h0001 << (`TIMEOUT_BASE + periodSel_r);
   wire overflow = active & running & ~starting_r & wdtTick &
      (count_r + 16'h0001 == limit);

   // AXI4-Lite slave, one outstanding write and read
   reg awHeld_r;
   reg wHeld_r;
   reg [3:0] awAddr_r;
   reg [31:0] wData_r;
   reg [3:0] wStrb_r;
   assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
   assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire doWrite = awHeld_r & wHeld_r;
   wire wrPeriod = doWrite & (awAddr_r == `ADDR_PERIOD_SELECT) & wStrb_r[0];
   wire wrControl = doWrite & (awAddr_r == `ADDR_CONTROL) & wStrb_r[0];
   wire wrOk = (awAddr_r == `ADDR_PERIOD_SELECT) |
      (awAddr_r == `ADDR_CONTROL) | (awAddr_r == `ADDR_STATUS) |
      (awAddr_r == `ADDR_COMMAND);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 4'h0;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrOk ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   reg [31:0] rdVal;
   reg rdOk;
   always @* begin
      rdOk = 1'b1;
      case (s_axi_araddr)
         `ADDR_PERIOD_SELECT: rdVal = {29'h0, periodSel_r};
         `ADDR_CONTROL: rdVal = {28'h0, enableKey_r};
         `ADDR_STATUS: rdVal = {27'h0, starting_r, ~running, active,
            sleeping, timeoutFlag};
         `ADDR_COMMAND: rdVal = 32'h0000_0000;
         default: begin
            rdVal = 32'h0000_0000;
            rdOk = 1'b0;
         end
      endcase
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdVal;
         s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Reset sequencer: hold while external reset, then delay, then run
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_HOLD;
         delay_r <= 32'h0000_0000;
      end else begin
         case (state_r)
            ST_HOLD: begin
               delay_r <= 32'h0000_0000;
               if (!extReset) begin
                  state_r <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (extReset) begin
                  state_r <= ST_HOLD;
               end else if (delay_r >= RESET_DELAY - 1) begin
                  state_r <= ST_RUN;
               end else begin
                  delay_r <= delay_r + 32'h0000_0001;
               end
            end
            ST_RUN: begin
               if (extReset) begin
                  state_r <= ST_HOLD;
               end
            end
            default: state_r <= ST_HOLD;
         endcase
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         periodSel_r <= `PERIOD_RESET;
         enableKey_r <= `KEY_RESET;
         count_r <= 16'h0000;
         div4_r <= 2'h0;
         lastPair_r <= 1'b0;
         pairSeen_r <= 1'b0;
         timeoutFlag <= 1'b0;
         sleeping <= 1'b0;
         coreResetN <= 1'b0;
         pcSpReset <= 1'b0;
         wakeUp <= 1'b0;
         startup_r <= 11'h000;
         starting_r <= 1'b0;
         portInit_r <= 1'b1;
         portData <= `PORT_RESET;
         portControl <= `PORT_RESET;
      end else begin
         pcSpReset <= 1'b0;
         wakeUp <= 1'b0;
         div4_r <= div4_r + 2'h1;
         portInit_r <= 1'b0;
         // Only full resets pull the core low; a sleep wake leaves it out
         coreResetN <= running & (coreResetN | ~starting_r);
         if (wrPeriod) begin
            periodSel_r <= wData_r[2:0];
         end
         if (wrControl) begin
            enableKey_r <= wData_r[3:0];
         end
         if (portInit_r) begin
            portData <= `PORT_RESET;
            portControl <= `PORT_RESET;
         end
         if (starting_r) begin
            if (startup_r == 11'h000) begin
               starting_r <= 1'b0;
            end else begin
               startup_r <= startup_r - 11'h001;
            end
         end
         if (extReset | !running) begin
            count_r <= 16'h0000;
            sleeping <= 1'b0;
            pairSeen_r <= 1'b0;
            periodSel_r <= `PERIOD_RESET;
            enableKey_r <= `KEY_RESET;
            coreResetN <= 1'b0;
         end else if (overflow & ~sleeping) begin
            count_r <= 16'h0000;
            timeoutFlag <= 1'b1;
            periodSel_r <= `PERIOD_RESET;
            enableKey_r <= `KEY_RESET;
            pairSeen_r <= 1'b0;
            coreResetN <= 1'b0;
            starting_r <= 1'b1;
            startup_r <= START_LONG_CNT;
         end else if (overflow) begin
            count_r <= 16'h0000;
            timeoutFlag <= 1'b1;
            sleeping <= 1'b0;
            wakeUp <= 1'b1;
            pcSpReset <= 1'b1;
            starting_r <= 1'b1;
            startup_r <= (cfgRcSysClock & cfgShortStartup) ?
               START_SHORT_CNT : START_LONG_CNT;
         end else if (cmdSleep) begin
            count_r <= 16'h0000;
            sleeping <= 1'b1;
            timeoutFlag <= 1'b0;
         end else if (cmdWake) begin
            sleeping <= 1'b0;
            wakeUp <= 1'b1;
         end else if (swClear) begin
            count_r <= 16'h0000;
            timeoutFlag <= 1'b0;
            pairSeen_r <= cfgPairClear;
            lastPair_r <= cmdSecond;
         end else if (active & wdtTick & ~starting_r) begin
            count_r <= count_r + 16'h0001;
         end
      end
   end
endmodule // watchdog_and_reset_sources

// ### test/wdt_checker_assertions.sv
// Checker for the watchdog block: reset sequencing, sleep wake, reads
// Bound to every instance; sees only the block's ports
`timescale 1ns/10ps
module wdt_checker #(
   parameter RESET_DELAY = 20
) (
   input wire sys_clk,
   input wire rst_n,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire externalResetPinN,
   input wire lowVoltageReset,
   input wire coreResetN,
   input wire pcSpReset,
   input wire wakeUp,
   input wire sleeping,
   input wire timeoutFlag,
   input wire [7:0] portData,
   input wire [7:0] portControl
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence pinHeldLow;
      !externalResetPinN [*3];
   endsequence
   sequence supplyLow;
      lowVoltageReset [*3];
   endsequence
   AST_PERIOD_ZERO:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0
         |=> s_axi_rdata[31:3] == 29'h0) else $error("period upper bits set");
   AST_PIN_RESET:
      assert property (pinHeldLow |-> ##[0:3] !coreResetN)
         else $error("pin low without core reset");
   AST_LV_RESET:
      assert property (supplyLow |-> ##[0:3] !coreResetN)
         else $error("low supply without core reset");
   AST_RESET_DELAY:
      assert property ($rose(coreResetN) |-> $past(externalResetPinN, RESET_DELAY))
         else $error("core released too soon");
   AST_PORTS_INIT:
      assert property ($rose(rst_n) |-> portData == 8'hFF && portControl == 8'hFF)
         else $error("ports not all ones");
   AST_WAKE_CAUSE:
      assert property (wakeUp |-> $past(sleeping))
         else $error("wake while not sleeping");
   AST_SLEEP_TIMEOUT:
      assert property (pcSpReset |-> coreResetN ##[0:1] timeoutFlag)
         else $error("sleep timeout handled wrongly");
   AST_PCSP_PULSE:
      assert property (pcSpReset |=> !pcSpReset)
         else $error("partial reset longer than a pulse");
endmodule // wdt_checker
bind watchdog_and_reset_sources wdt_checker #(
   .RESET_DELAY(RESET_DELAY)
) wdt_checker_inst (
   .sys_clk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .externalResetPinN, .lowVoltageReset, .coreResetN,
   .pcSpReset, .wakeUp, .sleeping, .timeoutFlag, .portData, .portControl
);

// ### test/watchdog_and_reset_sources_tb.sv
// Self-checking bench for the watchdog block
// Drives all ports; both slow clocks run at a quarter of sys_clk
`timescale 1ns/10ps
`include "wdt_map.vh"
module watchdog_and_reset_sources_tb;
   reg sys_clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   reg s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   reg [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
   reg [31:0] s_axi_wdata = 0, rv;
   reg cfgWdtEnable = 0, cfgPairClear = 0, externalResetPinN = 1;
   reg cfgShortStartup = 0, cfgRcSysClock = 0;
   reg [1:0] br, rr;
   reg lowVoltageReset = 0, slowClk = 0, low;
   reg [1:0] cfgClkSource = 2'h1, div = 2'h0;
   reg [4:0] coreCmd = 5'h00;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, coreResetN, pcSpReset, wakeUp, sleeping, timeoutFlag;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0] portData, portControl;
   integer n_mismatch = 0, tests_run = 0, cnt, i;
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      div <= div + 2'h1;
      slowClk <= div[1];
   end
   watchdog_and_reset_sources #(.RESET_DELAY(20), .STARTUP_LONG(8),
      .STARTUP_SHORT(2)) watchdog_and_reset_sources_inst (.sys_clk, .rst_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cfgWdtEnable, .cfgClkSource, .cfgPairClear,
      .cfgShortStartup, .cfgRcSysClock, .externalResetPinN,
      .lowVoltageReset, .lowFreqCrystalClock(slowClk),
      .lowSpeedInternalRc(slowClk), .coreCmd, .coreResetN, .pcSpReset,
      .wakeUp, .sleeping, .timeoutFlag, .portData, .portControl);
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", tests_run, n_mismatch);
         if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task hang;
      begin
         n_mismatch = n_mismatch + 1;
         $display("BAD wait expected done seen timeout");
         tally_and_finish;
      end
   endtask
   task chk(input [79:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0s expected %0h seen %0h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      integer k;
      reg done;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         done = 0;
         for (k = 0; k < 50 && !done; k = k + 1) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
               s_axi_bready <= 1'h0;
               br = s_axi_bresp;
               done = 1;
            end
         end
         if (!done) hang;
         @(posedge sys_clk);
      end
   endtask
   task rd(input [3:0] a);
      integer k;
      reg done;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         done = 0;
         for (k = 0; k < 50 && !done; k = k + 1) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
               s_axi_rready <= 1'h0;
               rv = s_axi_rdata;
               rr = s_axi_rresp;
               done = 1;
            end
         end
         if (!done) hang;
         @(posedge sys_clk);
      end
   endtask
   task waitCore(input v, input integer lim);
      begin
         cnt = 0;
         while (coreResetN !== v && cnt < lim) begin
            @(posedge sys_clk);
            cnt = cnt + 1;
         end
         if (cnt >= lim) hang;
      end
   endtask
   // Watches for any core reset over n cycles
   task idle(input integer n);
      begin
         low = 0;
         repeat (n) begin
            @(posedge sys_clk);
            if (coreResetN !== 1'b1) low = 1;
         end
      end
   endtask
   task pulse(input integer b);
      begin
         coreCmd <= 5'h01 << b;
         @(posedge sys_clk);
         coreCmd <= 5'h00;
         @(posedge sys_clk);
      end
   endtask
   task tRegs;
      begin
         waitCore(1, 100);
         chk("delay", cnt >= 20, 1);
         chk("portData", portData, 8'hFF);
         chk("portCtrl", portControl, 8'hFF);
         rd(`ADDR_PERIOD_SELECT);
         chk("period", rv, 32'h7);
         rd(`ADDR_CONTROL);
         chk("key", rv, 32'hA);
         wr(`ADDR_PERIOD_SELECT, 32'hFF);
         chk("wok", br, 2'h0);
         rd(`ADDR_PERIOD_SELECT);
         chk("upper", rv, 32'h7);
         chk("rok", rr, 2'h0);
         rd(`ADDR_COMMAND);
         chk("reserved", rv, 32'h0);
         wr(4'h2, 32'h1);
         chk("wresp", br, 2'h2);
         rd(4'h2);
         chk("rresp", rr, 2'h2);
         chk("unmapped", rv, 32'h0);
         wr(`ADDR_PERIOD_SELECT, 32'h0);
         idle(1500);
         chk("offrun", low, 0);
         $display("registers done");
      end
   endtask
   task tKeyRun;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            cfgClkSource <= i;
            wr(`ADDR_PERIOD_SELECT, i % 2);
            wr(`ADDR_CONTROL, 32'h5);
            waitCore(0, 5000);
            chk("tmo", cnt > (1000 << i % 2) && cnt < (1040 << i % 2), 1);
            chk("toflag", timeoutFlag, 1);
            waitCore(1, 100);
            chk("startup", cnt >= 8 && cnt <= 10, 1);
            rd(`ADDR_CONTROL);
            chk("keyinit", rv, 32'hA);
         end
         $display("timeouts done");
      end
   endtask
   task tClear;
      begin
         cfgWdtEnable <= 1'h1;
         wr(`ADDR_PERIOD_SELECT, 32'h0);
         for (i = 0; i < 3; i = i + 1) begin
            pulse(0);
            idle(800);
         end
         cfgPairClear <= 1'h1;
         for (i = 0; i < 3; i = i + 1) begin
            pulse(i == 1 ? 2 : 1);
            idle(800);
         end
         chk("cleared", low, 0);
         pulse(1);
         idle(400);
         chk("repeat", low, 1);
         waitCore(1, 100);
         $display("clears done");
      end
   endtask
   task tSleep;
      begin
         cfgClkSource <= `SRC_SYSDIV4;
         cfgRcSysClock <= 1'h1;
         cfgShortStartup <= 1'h1;
         wr(`ADDR_PERIOD_SELECT, 32'h0);
         pulse(3);
         idle(1500);
         chk("stopped", sleeping, 1);
         chk("noflag", timeoutFlag, 0);
         pulse(4);
         cfgClkSource <= `SRC_RC;
         pulse(3);
         for (cnt = 0; cnt < 1500 && wakeUp !== 1'b1; cnt = cnt + 1)
            @(posedge sys_clk);
         chk("sleeptmo", cnt > 1000 && cnt < 1040, 1);
         @(posedge sys_clk);
         chk("wakeflag", timeoutFlag, 1);
         chk("nofull", coreResetN, 1);
         rd(`ADDR_STATUS);
         chk("status", rv, 32'h5);
         cfgWdtEnable <= 1'h0;
         $display("sleep done");
      end
   endtask
   task tPin;
      begin
         for (i = 0; i < 2; i = i + 1) begin
            if (i == 0) externalResetPinN <= 1'h0;
            else lowVoltageReset <= 1'h1;
            repeat (5) @(posedge sys_clk);
            chk("corelow", coreResetN, 0);
            externalResetPinN <= 1'h1;
            lowVoltageReset <= 1'h0;
            @(posedge sys_clk);
            waitCore(1, 60);
            chk("pindelay", cnt >= 20, 1);
         end
         $display("pin resets done");
      end
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'h1;
      @(posedge sys_clk);
      tRegs;
      tKeyRun;
      tClear;
      tSleep;
      tPin;
      tally_and_finish;
   end
endmodule // watchdog_and_reset_sources_tb
